// ---- core/gpc_cfg.svh ----
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// Register addresses on the core I/O port
`define GPC_ADDR_IN_LO 4'h0
`define GPC_ADDR_DIR_LO 4'h1
`define GPC_ADDR_OUT_LO 4'h2
`define GPC_ADDR_IN_HI 4'h3
`define GPC_ADDR_DIR_HI 4'h4
`define GPC_ADDR_OUT_HI 4'h5
`define GPC_ADDR_FLAGS 4'h6
`define GPC_ADDR_MASK_LO 4'h7
`define GPC_ADDR_MASK_HI 4'h8
`define GPC_ADDR_GROUP_EN 4'h9
`define GPC_ADDR_CORE_CTRL 4'ha

// Field positions
`define GPC_UPPER_BIT 1
`define GPC_LOWER_BIT 0
`define GPC_PUD_BIT 0

// Reset values
`define GPC_RST_BYTE 8'h00
`define GPC_RST_PINS 16'h0000
`define GPC_RST_GROUP 2'h0

`endif

// ---- core/gpc_pkg.sv ----
package gpc_pkg;

    // One register byte
    typedef logic [7:0] gpc_byte_t;

    // Register address
    typedef logic [3:0] gpc_addr_t;

    // All sixteen pins, upper group in bits 15..8
    typedef logic [15:0] gpc_pins_t;

    // One bit for each pin-change group
    typedef logic [1:0] gpc_group_t;

endpackage

// ---- core/gpc_port.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gpc_cfg.svh"

module gpc_port
    import gpc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,

    // Core I/O access
    input wire gpc_addr_t io_addr_i,
    input wire logic io_wr_i,
    input wire gpc_byte_t io_wdata_i,
    input wire logic io_bit_set_i,
    input wire logic io_bit_clear_i,
    input wire logic [2:0] io_bit_sel_i,
    output gpc_byte_t io_rdata_o,

    // Core interrupt handshake
    input wire logic global_irq_enable_i,
    input wire gpc_group_t irq_ack_i,
    output gpc_group_t irq_o,

    // Port pins
    input wire gpc_pins_t pin_i,
    output gpc_pins_t pin_o,
    output gpc_pins_t pin_oe_o,
    output gpc_pins_t pin_pullup_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    gpc_pins_t dir_reg;
    gpc_pins_t out_reg;
    gpc_pins_t sync1_reg;
    gpc_pins_t sync2_reg;
    gpc_pins_t prev_reg;
    gpc_byte_t mask_hi_reg;
    gpc_byte_t mask_lo_reg;
    gpc_group_t group_en_reg;
    gpc_group_t flag_reg;
    logic pud_reg;
    gpc_byte_t rdata_reg;
    gpc_group_t irq_reg;
    gpc_pins_t pin_reg;
    gpc_pins_t oe_reg;
    gpc_pins_t pullup_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and read selection

    wire sel_in_lo = io_addr_i == `GPC_ADDR_IN_LO;
    wire sel_dir_lo = io_addr_i == `GPC_ADDR_DIR_LO;
    wire sel_out_lo = io_addr_i == `GPC_ADDR_OUT_LO;
    wire sel_in_hi = io_addr_i == `GPC_ADDR_IN_HI;
    wire sel_dir_hi = io_addr_i == `GPC_ADDR_DIR_HI;
    wire sel_out_hi = io_addr_i == `GPC_ADDR_OUT_HI;
    wire sel_flags = io_addr_i == `GPC_ADDR_FLAGS;
    wire sel_mask_lo = io_addr_i == `GPC_ADDR_MASK_LO;
    wire sel_mask_hi = io_addr_i == `GPC_ADDR_MASK_HI;
    wire sel_group = io_addr_i == `GPC_ADDR_GROUP_EN;
    wire sel_ctrl = io_addr_i == `GPC_ADDR_CORE_CTRL;

    // Input pin registers read the synchroniser output, never the pin
    wire gpc_byte_t rd_mux =
        sel_in_lo ? sync2_reg[7:0] :
        sel_dir_lo ? dir_reg[7:0] :
        sel_out_lo ? out_reg[7:0] :
        sel_in_hi ? sync2_reg[15:8] :
        sel_dir_hi ? dir_reg[15:8] :
        sel_out_hi ? out_reg[15:8] :
        sel_flags ? {6'h00, flag_reg} :
        sel_mask_lo ? mask_lo_reg :
        sel_mask_hi ? mask_hi_reg :
        sel_group ? {6'h00, group_en_reg} :
        sel_ctrl ? {7'h00, pud_reg} :
        8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Write data, with single-bit operations folded in
    // Toggle and write-one-to-clear registers must see only the addressed bit,
    // so a bit set there writes a lone one instead of read-modify-write.

    wire gpc_byte_t bit_onehot = 8'h01 << io_bit_sel_i;
    wire pulse_reg = sel_in_lo | sel_in_hi | sel_flags;
    wire wr_any = io_wr_i | io_bit_set_i | io_bit_clear_i;
    wire gpc_byte_t set_data = pulse_reg ? bit_onehot : (rd_mux | bit_onehot);
    wire gpc_byte_t clr_data = pulse_reg ? 8'h00 : (rd_mux & ~bit_onehot);
    wire gpc_byte_t wr_data = io_wr_i ? io_wdata_i : (io_bit_set_i ? set_data : clr_data);

    wire wr_in_lo = wr_any & sel_in_lo;
    wire wr_in_hi = wr_any & sel_in_hi;
    wire wr_dir_lo = wr_any & sel_dir_lo;
    wire wr_dir_hi = wr_any & sel_dir_hi;
    wire wr_out_lo = wr_any & sel_out_lo;
    wire wr_out_hi = wr_any & sel_out_hi;
    wire gpc_group_t flag_wr_clear = (wr_any & sel_flags) ? wr_data[1:0] : 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Next values of direction and output value registers

    wire gpc_pins_t dir_next = {wr_dir_hi ? wr_data : dir_reg[15:8],
                                wr_dir_lo ? wr_data : dir_reg[7:0]};
    wire gpc_pins_t toggle = {wr_in_hi ? wr_data : 8'h00,
                              wr_in_lo ? wr_data : 8'h00};
    wire gpc_pins_t out_next = {wr_out_hi ? wr_data : out_reg[15:8],
                                wr_out_lo ? wr_data : out_reg[7:0]} ^ toggle;

    // Direction and output value registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dir_reg <= `GPC_RST_PINS;
            out_reg <= `GPC_RST_PINS;
        end
        else
        begin
            dir_reg <= dir_next;
            out_reg <= out_next;
        end
    end

    // Control registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mask_hi_reg <= `GPC_RST_BYTE;
            mask_lo_reg <= `GPC_RST_BYTE;
            group_en_reg <= `GPC_RST_GROUP;
            pud_reg <= 1'b0;
        end
        else if (wr_any)
        begin
            if (sel_mask_hi)
                mask_hi_reg <= wr_data;
            if (sel_mask_lo)
                mask_lo_reg <= wr_data;
            if (sel_group)
                group_en_reg <= wr_data[1:0];
            if (sel_ctrl)
                pud_reg <= wr_data[`GPC_PUD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchroniser
    // Two flip-flops stand in for the latch-plus-flop pair, so a pin edge is
    // seen one to two clocks later instead of one half to one and a half.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= `GPC_RST_PINS;
            sync2_reg <= `GPC_RST_PINS;
            prev_reg <= `GPC_RST_PINS;
        end
        else
        begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Change detection and sticky flags

    wire gpc_pins_t pin_change = sync2_reg ^ prev_reg;
    wire change_hi = group_en_reg[`GPC_UPPER_BIT] & |(pin_change[15:8] & mask_hi_reg);
    wire change_lo = group_en_reg[`GPC_LOWER_BIT] & |(pin_change[7:0] & mask_lo_reg);
    wire gpc_group_t flag_set = {change_hi, change_lo};
    wire gpc_group_t flag_clear = flag_wr_clear | irq_ack_i;
    // A new change in the clearing cycle wins so no event is lost
    wire gpc_group_t flag_next = flag_set | (flag_reg & ~flag_clear);

    // Interrupt request, held off while an ack is clearing the flag
    wire gpc_group_t irq_next = flag_next & group_en_reg & {2{global_irq_enable_i}};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flag_reg <= `GPC_RST_GROUP;
            irq_reg <= `GPC_RST_GROUP;
            rdata_reg <= `GPC_RST_BYTE;
        end
        else
        begin
            flag_reg <= flag_next;
            irq_reg <= irq_next;
            rdata_reg <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, per pin so no pin's setting disturbs another

    wire gpc_pins_t pullup_next = ~dir_reg & out_reg & {16{~pud_reg}};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_reg <= `GPC_RST_PINS;
            pullup_reg <= `GPC_RST_PINS;
        end
        else
        begin
            pin_reg <= out_reg;
            pullup_reg <= pullup_next;
        end
    end

    // Output enables fall with reset alone, even with the clock stopped
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            oe_reg <= `GPC_RST_PINS;
        else
            oe_reg <= dir_reg;
    end

    assign io_rdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign pin_o = pin_reg;
    assign pin_oe_o = oe_reg;
    assign pin_pullup_o = pullup_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    flag_upper_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (group_en_reg[1] && |((sync2_reg[15:8] ^ prev_reg[15:8]) & mask_hi_reg)) |=> flag_reg[1])
        else $error("upper change flag not set after unmasked change");

    flag_lower_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (group_en_reg[0] && |((sync2_reg[7:0] ^ prev_reg[7:0]) & mask_lo_reg)) |=> flag_reg[0])
        else $error("lower change flag not set after unmasked change");

    irq_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!global_irq_enable_i || !group_en_reg[1] || !flag_next[1]) |=> !irq_o[1])
        else $error("upper interrupt raised without enables and flag");

    ack_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (irq_ack_i[1] && !change_hi) |=> !flag_reg[1] && !irq_o[1])
        else $error("upper flag survived handler entry");

    ack_lower_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (irq_ack_i[0] && !change_lo) |=> !flag_reg[0] && !irq_o[0])
        else $error("lower flag survived handler entry");

    flag_w1c_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (io_wr_i && sel_flags && !io_wdata_i[0] && !irq_ack_i[0]) |=> $stable(flag_reg[0]) || flag_reg[0])
        else $error("writing zero cleared the lower flag");

    flag_reserved_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_flags |=> io_rdata_o[7:2] == 6'h00)
        else $error("reserved flag bits read nonzero");

    mask_block_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!flag_reg[1] && (!group_en_reg[1] || (pin_change[15:8] & mask_hi_reg) == 8'h00)) |=> !flag_reg[1])
        else $error("upper flag set by a masked or disabled pin");

    mask_lower_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!flag_reg[0] && (!group_en_reg[0] || (pin_change[7:0] & mask_lo_reg) == 8'h00)) |=> !flag_reg[0])
        else $error("lower flag set by a masked or disabled pin");

    toggle_out_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (io_wr_i && sel_in_lo) |=> out_reg[7:0] == ($past(out_reg[7:0]) ^ $past(io_wdata_i)))
        else $error("input pin write did not toggle output value");

    toggle_hi_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (io_bit_set_i && !io_wr_i && sel_in_hi) |=>
            out_reg[15:8] == ($past(out_reg[15:8]) ^ $past(bit_onehot)))
        else $error("input pin bit set did not toggle one output bit");

    bit_op_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (io_bit_set_i && !io_wr_i && sel_dir_hi) |=>
            dir_reg[15:8] == ($past(dir_reg[15:8]) | $past(bit_onehot)))
        else $error("bit set disturbed other direction bits");

    pullup_off_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pud_reg |=> pin_pullup_o == 16'h0000)
        else $error("pull-up on while globally disabled");

    pullup_on_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> pin_pullup_o == ($past(out_reg) & ~$past(dir_reg) & {16{!$past(pud_reg)}}))
        else $error("pull-up does not follow input pins with output value one");

    oe_follow_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> pin_oe_o == $past(dir_reg))
        else $error("output enables do not follow the direction bits");

    sync_delay_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ##1 sync2_reg == $past(pin_i, 2))
        else $error("synchronised pin value does not lag the pin by two clocks");

    drive_dir_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(dir_reg[0]) |=> pin_oe_o[0] && pin_o[0] == $past(out_reg[0]))
        else $error("output pin not driving its value");

    reset_tristate_a: assert property (
        @(posedge clk_i) $fell(rst_i) |-> pin_oe_o == 16'h0000)
        else $error("pins driven at reset release");

endmodule

`default_nettype wire

// ---- core/unused_placeholder_none.sv ----
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- testbench/gpc_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module gpc_pin_model
    import gpc_pkg::*;
(
    // Clock
    input wire logic clk_i,

    // Block pin drivers
    input wire gpc_pins_t blk_out_i,
    input wire gpc_pins_t blk_oe_i,
    input wire gpc_pins_t blk_pu_i,

    // External drivers from the bench
    input wire gpc_pins_t ext_val_i,
    input wire gpc_pins_t ext_en_i,

    // Resolved pin levels
    output gpc_pins_t pin_lvl_o
);
    ////////////////////////////////////////////////////////////////////////
    gpc_pins_t drv_w;
    gpc_pins_t float_reg = 16'h0000;

    // Block driver wins, then the outside world, then the pull-up
    assign drv_w = blk_oe_i | ext_en_i | blk_pu_i;
    assign pin_lvl_o = (blk_oe_i & blk_out_i) | (~blk_oe_i & ext_en_i & ext_val_i)
        | (~blk_oe_i & ~ext_en_i & (blk_pu_i | (~drv_w & float_reg)));

    // A floating pin takes the inverse of its last level, so stale data never reads back
    always @(posedge clk_i)
    begin
        float_reg <= (drv_w & ~pin_lvl_o) | (~drv_w & float_reg);
    end
endmodule

`default_nettype wire

// ---- testbench/gpio_port_with_pin_change_irq_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gpc_cfg.svh"

module gpio_port_with_pin_change_irq_tb
    import gpc_pkg::*;
();
    ////////////////////////////////////////////////////////////////////////
    logic clk_i = 0;
    logic rst_i = 1;
    gpc_addr_t addr = 0;
    logic wr = 0;
    logic bset = 0;
    logic bclr = 0;
    gpc_byte_t wdata = 0;
    logic [2:0] bsel = 0;
    logic gie = 0;
    gpc_group_t ack = 0;
    gpc_pins_t ext_v = 16'h5a96;
    gpc_pins_t ext_en = 16'hffff;
    gpc_byte_t rdata;
    gpc_group_t irq;
    gpc_pins_t pin_o;
    gpc_pins_t oe;
    gpc_pins_t pu;
    gpc_pins_t lvl;
    gpc_pins_t exp_pins;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    gpc_port gpc_port_inst (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(addr), .io_wr_i(wr),
        .io_wdata_i(wdata), .io_bit_set_i(bset), .io_bit_clear_i(bclr), .io_bit_sel_i(bsel),
        .io_rdata_o(rdata), .global_irq_enable_i(gie), .irq_ack_i(ack), .irq_o(irq),
        .pin_i(lvl), .pin_o(pin_o), .pin_oe_o(oe), .pin_pullup_o(pu));

    gpc_pin_model gpc_pin_model_inst (.clk_i(clk_i), .blk_out_i(pin_o), .blk_oe_i(oe),
        .blk_pu_i(pu), .ext_val_i(ext_v), .ext_en_i(ext_en), .pin_lvl_o(lvl));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Case equality so an unknown never counts as a match
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask

    task automatic wr_reg(input gpc_addr_t a, input gpc_byte_t d);
        idle(1);
        addr = a;
        wdata = d;
        wr = 1;
        idle(1);
        wr = 0;
    endtask

    task automatic bit_op(input gpc_addr_t a, input logic [2:0] n, input logic set);
        idle(1);
        addr = a;
        bsel = n;
        bset = set;
        bclr = !set;
        idle(1);
        bset = 0;
        bclr = 0;
    endtask

    // Read data follows the address one edge later
    task automatic rd_chk(input gpc_addr_t a, input gpc_byte_t exp);
        idle(1);
        addr = a;
        idle(1);
        chk("io_rdata_o", {8'h00, exp}, {8'h00, rdata});
    endtask

    // Hang guard, the sequence needs about 140 cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        idle(1);
        chk("pin_oe_o", 16'h0000, oe);
        idle(1);
        rst_i = 0;
        // Let the outside pin levels pass the synchroniser first
        idle(2);
        for (int a = 0; a < 16; a++)
            rd_chk(a[3:0], (a == 0) ? ext_v[7:0] : ((a == 3) ? ext_v[15:8] : 8'h00));
        wr_reg(`GPC_ADDR_DIR_LO, 8'ha5);
        wr_reg(`GPC_ADDR_OUT_LO, 8'h3c);
        idle(2);
        chk("pin_oe_o", 16'h00a5, oe);
        chk("pin_o", 16'h0024, pin_o & oe);
        chk("pin_pullup_o", 16'h0018, pu);
        wr_reg(`GPC_ADDR_CORE_CTRL, 8'h01);
        idle(2);
        chk("pin_pullup_o", 16'h0000, pu);
        wr_reg(`GPC_ADDR_CORE_CTRL, 8'h00);
        wr_reg(`GPC_ADDR_IN_LO, 8'h0f);
        rd_chk(`GPC_ADDR_OUT_LO, 8'h33);
        bit_op(`GPC_ADDR_DIR_HI, 3'h3, 1'b1);
        bit_op(`GPC_ADDR_OUT_LO, 3'h5, 1'b0);
        bit_op(`GPC_ADDR_IN_HI, 3'h0, 1'b1);
        rd_chk(`GPC_ADDR_DIR_HI, 8'h08);
        rd_chk(`GPC_ADDR_OUT_LO, 8'h13);
        rd_chk(`GPC_ADDR_OUT_HI, 8'h01);
        idle(3);
        chk("pin_pullup_o", 16'h0112, pu);
        // Output pins read back their drive, inputs the outside level
        exp_pins = (16'h08a5 & 16'h0113) | (~16'h08a5 & ext_v);
        rd_chk(`GPC_ADDR_IN_LO, exp_pins[7:0]);
        rd_chk(`GPC_ADDR_IN_HI, exp_pins[15:8]);
        // Upper group: masked pin first, then an enabled one
        gie = 1;
        wr_reg(`GPC_ADDR_MASK_HI, 8'h02);
        wr_reg(`GPC_ADDR_GROUP_EN, 8'h02);
        ext_v[10] = ~ext_v[10];
        idle(6);
        rd_chk(`GPC_ADDR_FLAGS, 8'h00);
        ext_v[9] = ~ext_v[9];
        idle(6);
        chk("irq_o", 16'h0002, {14'h0, irq});
        rd_chk(`GPC_ADDR_FLAGS, 8'h02);
        ack = 2'b10;
        idle(1);
        ack = 2'b00;
        idle(1);
        chk("irq_o", 16'h0000, {14'h0, irq});
        rd_chk(`GPC_ADDR_FLAGS, 8'h00);
        // Lower group: disabled group, then enabled with interrupts off
        wr_reg(`GPC_ADDR_MASK_LO, 8'h02);
        ext_v[1] = ~ext_v[1];
        idle(6);
        rd_chk(`GPC_ADDR_FLAGS, 8'h00);
        wr_reg(`GPC_ADDR_GROUP_EN, 8'h03);
        gie = 0;
        ext_v[1] = ~ext_v[1];
        idle(6);
        rd_chk(`GPC_ADDR_FLAGS, 8'h01);
        chk("irq_o", 16'h0000, {14'h0, irq});
        wr_reg(`GPC_ADDR_FLAGS, 8'hfe);
        rd_chk(`GPC_ADDR_FLAGS, 8'h01);
        wr_reg(`GPC_ADDR_FLAGS, 8'hff);
        rd_chk(`GPC_ADDR_FLAGS, 8'h00);
        rd_chk(`GPC_ADDR_GROUP_EN, 8'h03);
        // Handler entry clears the lower flag too
        ext_v[1] = ~ext_v[1];
        idle(6);
        rd_chk(`GPC_ADDR_FLAGS, 8'h01);
        ack = 2'b01;
        idle(1);
        ack = 2'b00;
        rd_chk(`GPC_ADDR_FLAGS, 8'h00);
        // Reset in mid-run must tristate at once, before any clock edge
        rst_i = 1;
        #1;
        chk("pin_oe_o", 16'h0000, oe);
        idle(2);
        rst_i = 0;
        rd_chk(`GPC_ADDR_GROUP_EN, 8'h00);
        rd_chk(`GPC_ADDR_DIR_HI, 8'h00);
        tally_and_finish();
    end
endmodule

`default_nettype wire
